// ---- common/fgls_pkg.sv ----
// Purpose: shared constants and the opcode decoder of the load, store, shift and
//          immediate part of the foreground instruction set
// Assumes: one processor clock, all times in clock periods
// Notes:   opcodes below the indirect memory group issue as a pass
//
// What this block does
// RQ1: opcode 075 stores second at first's address
// RQ2: opcode 076 loads second self-addressed, six periods
// RQ3: opcode 077 stores second self-addressed, frees next
// RQ4: 100-137 shift second right, zero fill
// RQ5: 140-177 shift second left by 32-count
// RQ6: left shift count zero clears second
// RQ7: shifts hold second four periods, issue next
// RQ8: 200-217 load first with four-bit constant
// RQ9: 220-237 load first with twelve-bit constant
// RQ10: 240-257 load first from direct address
// RQ11: 260-277 store first at direct address
// RQ12: 300-317 load second with four-bit constant
// RQ13: 320-337 load second with twelve-bit constant
// RQ14: 340-357 load second from direct address
// RQ15: 360-377 store second at direct address
// RQ16: two-byte forms delay next issue two periods
// RQ17: memory ops wait memory free, hold four
// RQ18: issue needs used accumulators free; stores release
// RQ19: opcode 074 loads second at first's address
// RQ20: busy countdown per resource gates issue

package fgls_pkg;

    // ------------------------------------------------------------------
    // resources and busy times
    // ------------------------------------------------------------------
    localparam int          FGLS_NRES       = 3;
    localparam int          FGLS_CW         = 3;
    localparam int          FGLS_RES_FIRST  = 0;
    localparam int          FGLS_RES_SECOND = 1;
    localparam int          FGLS_RES_MEM    = 2;
    localparam logic [2:0]  FGLS_LOAD_FREE  = 3'h6;
    localparam logic [2:0]  FGLS_STORE_FREE = 3'h1;
    localparam logic [2:0]  FGLS_SHIFT_FREE = 3'h4;
    localparam logic [2:0]  FGLS_CONST_FREE = 3'h3;
    localparam logic [2:0]  FGLS_MEM_FREE   = 3'h4;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [5:0]  FGLS_OP_INDIRECT = 6'h0F;
    localparam logic [1:0]  FGLS_OP_SHIFT    = 2'h1;
    localparam logic [1:0]  FGLS_SUB_LD_AT_A = 2'h0;
    localparam logic [1:0]  FGLS_SUB_ST_AT_A = 2'h1;
    localparam logic [1:0]  FGLS_SUB_LD_AT_B = 2'h2;
    localparam logic [1:0]  FGLS_SUB_ST_AT_B = 2'h3;
    localparam logic [7:0]  FGLS_RESET_OP    = 8'h00;

    typedef struct packed {
        logic       two_byte;
        logic       need_first;
        logic       need_second;
        logic       need_mem;
        logic       mem_rd;
        logic       mem_wr;
        logic [2:0] hold_first;
        logic [2:0] hold_second;
    } fgls_dec_s;

    // countdown value for a resource that is free again after t periods
    function automatic logic [2:0] fgls_hold(input logic [2:0] t);
        return t - 3'h1;
    endfunction

    function automatic fgls_dec_s fgls_decode(input logic [7:0] op);
        fgls_dec_s  d;
        logic [2:0] h;
        d = '0;
        h = '0;
        if (op[7:2] == FGLS_OP_INDIRECT) begin
            d.need_second = 1'b1;
            d.need_mem    = 1'b1;
            d.mem_rd      = ~op[0];
            d.mem_wr      = op[0];
            d.need_first  = ~op[1];
            d.hold_second = op[0] ? fgls_hold(FGLS_STORE_FREE) : fgls_hold(FGLS_LOAD_FREE);
        end else if (op[7:6] == FGLS_OP_SHIFT) begin
            d.need_second = 1'b1;
            d.hold_second = fgls_hold(FGLS_SHIFT_FREE);
        end else if (op[7]) begin
            d.two_byte = op[5] | op[4];
            d.need_mem = op[5];
            d.mem_rd   = op[5] & ~op[4];
            d.mem_wr   = op[5] & op[4];
            if (!op[5]) begin
                h = fgls_hold(FGLS_CONST_FREE);
            end else if (!op[4]) begin
                h = fgls_hold(FGLS_LOAD_FREE);
            end else begin
                h = fgls_hold(FGLS_STORE_FREE);
            end
            d.need_first  = ~op[6];
            d.need_second = op[6];
            d.hold_first  = op[6] ? 3'h0 : h;
            d.hold_second = op[6] ? h : 3'h0;
        end
        return d;
    endfunction

endpackage

// ---- common/fgls_busy_if.sv ----
// Purpose: carries busy countdown loads and values between issue and timer
// Assumes: one clock domain
// Notes:   next_cnt lets the issue logic look one edge ahead
`timescale 1ns/1ps

interface fgls_busy_if;
    import fgls_pkg::*;
    logic [FGLS_NRES-1:0] load;
    logic [FGLS_CW-1:0]   load_val [FGLS_NRES];
    logic [FGLS_CW-1:0]   cnt      [FGLS_NRES];
    logic [FGLS_CW-1:0]   next_cnt [FGLS_NRES];

    modport timer (input load, input load_val, output cnt, output next_cnt);
    modport issue (output load, output load_val, input cnt, input next_cnt);
endinterface

// ---- verilog/fgls_busy_timer.sv ----
// Purpose: one busy countdown per resource
// Assumes: a load only comes while that resource is free
// Notes:   zero means free
`timescale 1ns/1ps

module fgls_busy_timer (
    input  wire logic   core_clk_i,
    input  wire logic   rst_i,
    fgls_busy_if.timer  bus
);
    import fgls_pkg::*;

    // ------------------------------------------------------------------
    // countdowns
    // ------------------------------------------------------------------
    logic [FGLS_CW-1:0] cnt [FGLS_NRES];

    for (genvar i = 0; i < FGLS_NRES; i++) begin : g_res
        always_comb begin
            if (bus.load[i]) begin
                bus.next_cnt[i] = bus.load_val[i]; // RQ20
            end else if (cnt[i] != '0) begin
                bus.next_cnt[i] = cnt[i] - 3'h1; // RQ20
            end else begin
                bus.next_cnt[i] = '0;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                cnt[i] <= '0;
            end else begin
                cnt[i] <= bus.next_cnt[i];
            end
        end

        assign bus.cnt[i] = cnt[i];
    end
endmodule

// ---- verilog/fgls_issue_core.sv ----
// Purpose: issue stage and execution of loads, stores, shifts and immediates
// Assumes: memory answers a read 1 to 3 cycles after mem_req_o, in order
// Notes:   bytes are taken on instr_valid_i and instr_ready_o both high
`timescale 1ns/1ps

module fgls_issue_core (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        instr_valid_i,
    input  wire logic [7:0]  instr_byte_i,
    output logic             instr_ready_o,
    output logic             issue_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [11:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    input  wire logic        mem_rvalid_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic [31:0]      acc_first_o,
    output logic [31:0]      acc_second_o
);
    import fgls_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        slot_valid;
    logic [7:0]  slot_op;
    logic        ready;
    logic        issued;
    logic [7:0]  last_op;
    logic [31:0] acc_first;
    logic [31:0] acc_second;
    logic        ld_pend;
    logic        ld_to_second;
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [31:0] wdata;

    logic        next_slot_valid;
    logic [7:0]  next_slot_op;
    logic        next_ready;
    logic        next_issued;
    logic [7:0]  next_last_op;
    logic [31:0] next_acc_first;
    logic [31:0] next_acc_second;
    logic        next_ld_pend;
    logic        next_ld_to_second;
    logic        next_req;
    logic        next_we;
    logic [11:0] next_addr;
    logic [31:0] next_wdata;

    fgls_dec_s   dec;
    logic        can_issue;
    logic        issue;
    logic        take;
    logic [11:0] imm12;
    logic [4:0]  sh_cnt;
    logic [63:0] left_wide;

    fgls_busy_if tim ();

    fgls_busy_timer u_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .bus        (tim.timer)
    );

    // ------------------------------------------------------------------
    // issue checks
    // ------------------------------------------------------------------
    function automatic logic free_for(input fgls_dec_s d,
                                      input logic [2:0] c_first,
                                      input logic [2:0] c_second,
                                      input logic [2:0] c_mem);
        return !(d.need_first && c_first != '0)
            && !(d.need_second && c_second != '0)
            && !(d.need_mem && c_mem != '0);
    endfunction

    always_comb begin
        dec       = fgls_decode(slot_op);
        can_issue = slot_valid && free_for(dec, tim.cnt[FGLS_RES_FIRST],
                        tim.cnt[FGLS_RES_SECOND], tim.cnt[FGLS_RES_MEM]); // RQ18 RQ17
        issue     = can_issue && (!dec.two_byte || instr_valid_i); // RQ16
        take      = instr_valid_i && ready;
        imm12     = {slot_op[3:0], instr_byte_i}; // RQ9 RQ13
        sh_cnt    = slot_op[4:0];
        left_wide = {acc_second, 32'h0} >> sh_cnt; // RQ5
    end

    always_comb begin
        tim.load[FGLS_RES_FIRST]      = issue && dec.need_first; // RQ20
        tim.load[FGLS_RES_SECOND]     = issue && dec.need_second; // RQ20
        tim.load[FGLS_RES_MEM]        = issue && dec.need_mem; // RQ17
        tim.load_val[FGLS_RES_FIRST]  = dec.hold_first; // RQ18
        tim.load_val[FGLS_RES_SECOND] = dec.hold_second; // RQ2 RQ7 RQ18
        tim.load_val[FGLS_RES_MEM]    = fgls_hold(FGLS_MEM_FREE); // RQ17
    end

    // ------------------------------------------------------------------
    // issue slot and ready
    // ------------------------------------------------------------------
    always_comb begin
        next_slot_valid = slot_valid;
        next_slot_op    = slot_op;
        if (issue && dec.two_byte) begin
            next_slot_valid = 1'b0; // RQ16
        end else if (take) begin
            next_slot_valid = 1'b1;
            next_slot_op    = instr_byte_i;
        end else if (issue) begin
            next_slot_valid = 1'b0;
        end
        // looks one edge ahead so the registered ready allows one issue a cycle
        next_ready = !next_slot_valid
                  || free_for(fgls_decode(next_slot_op), tim.next_cnt[FGLS_RES_FIRST],
                        tim.next_cnt[FGLS_RES_SECOND], tim.next_cnt[FGLS_RES_MEM]); // RQ18
        next_issued  = issue;
        next_last_op = issue ? slot_op : last_op;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slot_valid <= 1'b0;
            slot_op    <= FGLS_RESET_OP;
            ready      <= 1'b1;
            issued     <= 1'b0;
            last_op    <= FGLS_RESET_OP;
        end else begin
            slot_valid <= next_slot_valid;
            slot_op    <= next_slot_op;
            ready      <= next_ready;
            issued     <= next_issued;
            last_op    <= next_last_op;
        end
    end

    // ------------------------------------------------------------------
    // execution: accumulators and memory port
    // ------------------------------------------------------------------
    always_comb begin
        next_acc_first    = acc_first;
        next_acc_second   = acc_second;
        next_ld_pend      = ld_pend;
        next_ld_to_second = ld_to_second;
        next_req          = 1'b0;
        next_we           = 1'b0;
        next_addr         = addr;
        next_wdata        = wdata;
        if (mem_rvalid_i && ld_pend) begin
            next_ld_pend = 1'b0;
            if (ld_to_second) begin
                next_acc_second = mem_rdata_i; // RQ2 RQ14 RQ19
            end else begin
                next_acc_first = mem_rdata_i; // RQ10
            end
        end
        if (issue) begin
            if (slot_op[7:2] == FGLS_OP_INDIRECT) begin
                next_req   = 1'b1;
                next_we    = dec.mem_wr; // RQ1 RQ3
                next_addr  = slot_op[1] ? acc_second[11:0] : acc_first[11:0]; // RQ1 RQ19
                next_wdata = acc_second; // RQ1 RQ3
                if (dec.mem_rd) begin
                    next_ld_pend      = 1'b1; // RQ2 RQ19
                    next_ld_to_second = 1'b1;
                end
            end else if (slot_op[7:6] == FGLS_OP_SHIFT) begin
                if (!slot_op[5]) begin
                    next_acc_second = acc_second >> sh_cnt; // RQ4
                end else begin
                    next_acc_second = left_wide[31:0]; // RQ5 RQ6
                end
            end else if (slot_op[7] && !slot_op[5]) begin
                if (slot_op[6]) begin
                    next_acc_second = slot_op[4] ? {20'h0, imm12}
                                                 : {28'h0, slot_op[3:0]}; // RQ12 RQ13
                end else begin
                    next_acc_first = slot_op[4] ? {20'h0, imm12}
                                                : {28'h0, slot_op[3:0]}; // RQ8 RQ9
                end
            end else if (slot_op[7]) begin
                next_req   = 1'b1;
                next_we    = dec.mem_wr; // RQ11 RQ15
                next_addr  = imm12; // RQ10 RQ11 RQ14 RQ15
                next_wdata = slot_op[6] ? acc_second : acc_first; // RQ11 RQ15
                if (dec.mem_rd) begin
                    next_ld_pend      = 1'b1; // RQ10 RQ14
                    next_ld_to_second = slot_op[6];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_first    <= 32'h0;
            acc_second   <= 32'h0;
            ld_pend      <= 1'b0;
            ld_to_second <= 1'b0;
            req          <= 1'b0;
            we           <= 1'b0;
            addr         <= 12'h0;
            wdata        <= 32'h0;
        end else begin
            acc_first    <= next_acc_first;
            acc_second   <= next_acc_second;
            ld_pend      <= next_ld_pend;
            ld_to_second <= next_ld_to_second;
            req          <= next_req;
            we           <= next_we;
            addr         <= next_addr;
            wdata        <= next_wdata;
        end
    end

    assign instr_ready_o = ready;
    assign issue_o       = issued;
    assign mem_req_o     = req;
    assign mem_we_o      = we;
    assign mem_addr_o    = addr;
    assign mem_wdata_o   = wdata;
    assign acc_first_o   = acc_first;
    assign acc_second_o  = acc_second;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_second_held5;
        (tim.cnt[FGLS_RES_SECOND] != 3'h0) [*5] ##1 (tim.cnt[FGLS_RES_SECOND] == 3'h0);
    endsequence

    sequence s_second_held3;
        (tim.cnt[FGLS_RES_SECOND] != 3'h0) [*3] ##1 (tim.cnt[FGLS_RES_SECOND] == 3'h0);
    endsequence

    chk_store_at_first: assert property ( // RQ1
        (issue && slot_op == 8'h3D) |=> (mem_req_o && mem_we_o
            && mem_addr_o == $past(acc_first[11:0]) && mem_wdata_o == $past(acc_second)))
        else $error("store at first address wrong");

    chk_self_load_hold: assert property ( // RQ2
        (issue && slot_op == 8'h3E) |=> s_second_held5)
        else $error("self-addressed load hold time wrong");

    chk_self_store_free: assert property ( // RQ3
        (issue && slot_op == 8'h3F) |=> (tim.cnt[FGLS_RES_SECOND] == 3'h0 && mem_we_o
            && mem_addr_o == $past(acc_second[11:0])))
        else $error("self-addressed store wrong");

    chk_right_shift: assert property ( // RQ4
        (issue_o && last_op[7:5] == 3'h2)
            |-> acc_second == ($past(acc_second) >> last_op[4:0]))
        else $error("right shift result wrong");

    chk_left_shift: assert property ( // RQ5
        (issue_o && last_op[7:5] == 3'h3 && last_op[4:0] != 5'h00)
            |-> acc_second == ($past(acc_second) << (6'd32 - {1'b0, last_op[4:0]})))
        else $error("left shift result wrong");

    chk_left_zero: assert property ( // RQ6
        (issue_o && last_op == 8'h60) |-> acc_second == 32'h0)
        else $error("zero count left shift did not clear");

    chk_shift_hold: assert property ( // RQ7
        (issue && slot_op[7:6] == FGLS_OP_SHIFT) |=> s_second_held3)
        else $error("shift hold time wrong");

    chk_short_const: assert property ( // RQ8
        (issue_o && last_op[7:4] == 4'h8) |-> acc_first == {28'h0, last_op[3:0]})
        else $error("short constant to first wrong");

    chk_long_const: assert property ( // RQ9
        (issue && slot_op[7:4] == 4'h9)
            |=> acc_first == {20'h0, $past(slot_op[3:0]), $past(instr_byte_i)})
        else $error("long constant to first wrong");

    chk_direct_store: assert property ( // RQ11
        (issue && slot_op[7:4] == 4'hB) |=> (mem_we_o && mem_addr_o == $past(imm12)
            && mem_wdata_o == $past(acc_first)))
        else $error("direct store of first wrong");

    chk_two_byte_gap: assert property ( // RQ16
        (issue && dec.two_byte) |=> !issue)
        else $error("issue too soon after two-byte form");

    chk_mem_busy: assert property ( // RQ17
        (issue && dec.need_mem) |-> tim.cnt[FGLS_RES_MEM] == 3'h0
            ##1 tim.cnt[FGLS_RES_MEM] == 3'h3 ##3 tim.cnt[FGLS_RES_MEM] == 3'h0)
        else $error("memory busy interlock wrong");

    chk_acc_interlock: assert property ( // RQ18
        (issue && dec.need_first) |-> tim.cnt[FGLS_RES_FIRST] == 3'h0)
        else $error("issued while first accumulator busy");
endmodule

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the load, store, shift and immediate issue core
// Assumes: the bench stands in for local memory and answers reads 1 to 3 cycles late
// Notes:   issue spacing is judged from busy times kept against observed issue pulses
`timescale 1ns/1ps

module tb;
    import fgls_pkg::*;

    // ------------------------------------------------------------------
    // notes shared by driver and monitor
    // ------------------------------------------------------------------
    typedef struct {
        logic [2:0]  need;
        int          t [3];
        bit          two;
        bit          chk;
        bit          sel;
        logic [31:0] val;
        bit          fresh;
    } fgls_ent_s;

    typedef struct {
        logic        we;
        logic [11:0] addr;
        logic [31:0] data;
    } fgls_mreq_s;

    logic        core_clk_i = 1'b0;
    logic        rst_i;
    logic        instr_valid_i;
    logic [7:0]  instr_byte_i;
    logic        instr_ready_o;
    logic        issue_o;
    logic        mem_req_o;
    logic        mem_we_o;
    logic [11:0] mem_addr_o;
    logic [31:0] mem_wdata_o;
    logic        mem_rvalid_i;
    logic [31:0] mem_rdata_i;
    logic [31:0] acc_first_o;
    logic [31:0] acc_second_o;

    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    fgls_ent_s   iss_q [$];
    fgls_mreq_s  mem_q [$];
    logic [31:0] rd_q [$];
    logic [32:0] ld_q [$];
    logic [31:0] m [4096];
    logic [31:0] ea;
    logic [31:0] eb;
    int          lastt, lastgap, lo, sp, rb, tol;
    int          free_at [3];
    bit          pst, ld_pend;
    logic [32:0] ld_e;
    logic [31:0] got;
    fgls_ent_s   e;
    fgls_mreq_s  mr;
    int          lat;

    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;

    fgls_issue_core u_fgls_issue_core (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .instr_valid_i (instr_valid_i),
        .instr_byte_i  (instr_byte_i),
        .instr_ready_o (instr_ready_o),
        .issue_o       (issue_o),
        .mem_req_o     (mem_req_o),
        .mem_we_o      (mem_we_o),
        .mem_addr_o    (mem_addr_o),
        .mem_wdata_o   (mem_wdata_o),
        .mem_rvalid_i  (mem_rvalid_i),
        .mem_rdata_i   (mem_rdata_i),
        .acc_first_o   (acc_first_o),
        .acc_second_o  (acc_second_o)
    );

    // ------------------------------------------------------------------
    // common tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input bit ok, input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (!ok) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic send(input logic [7:0] b);
        bit r;
        int n;
        instr_valid_i <= 1'b1;
        instr_byte_i  <= b;
        n = 0;
        do begin
            @(negedge core_clk_i);
            r = (instr_ready_o === 1'b1);
            @(posedge core_clk_i);
            n++;
        end while (!r && n < 30);
        if (!r) chk(1'b0, {24'h0, b}, 32'h0);
    endtask

    task automatic mem_note(input logic we, input logic [11:0] a, input logic [31:0] d,
                            input logic sel);
        mem_q.push_back('{we, a, d});
        if (we) begin
            m[a] = d;
        end else begin
            rd_q.push_back(m[a]);
            ld_q.push_back({sel, m[a]});
        end
    endtask

    // model of one instruction: notes results and busy times, then sends its bytes
    task automatic exec(input logic [7:0] op, input logic [7:0] b2, input bit fresh);
        fgls_ent_s   x;
        logic [11:0] a;
        logic [31:0] v;
        int          c;
        int          hold;
        x.need = 3'b000;
        x.t = '{1, 1, 1};
        x.two = 1'b0;
        x.chk = 1'b0;
        x.sel = 1'b0;
        x.val = 32'h0;
        x.fresh = fresh;
        c = int'(op[4:0]);
        if (op < 8'h40) begin
            x.need = {2'b11, ~op[1]};
            x.t[2] = 4;
            a = op[1] ? eb[11:0] : ea[11:0];
            mem_note(op[0], a, eb, 1'b1);
            if (!op[0]) begin
                x.t[1] = 6;
                eb = m[a];
            end
        end else if (op < 8'h80) begin
            x.need = 3'b010;
            x.t[1] = 4;
            x.chk = 1'b1;
            x.sel = 1'b1;
            if (!op[5]) eb = eb >> c;
            else if (c == 0) eb = 32'h0;
            else eb = eb << (32 - c);
            x.val = eb;
        end else begin
            x.sel = op[6];
            x.two = op[5] | op[4];
            a = {op[3:0], b2};
            v = x.sel ? eb : ea;
            hold = 3;
            if (!op[5]) begin
                x.chk = 1'b1;
                v = op[4] ? {20'h0, a} : {28'h0, op[3:0]};
                x.val = v;
            end else begin
                x.need[2] = 1'b1;
                x.t[2] = 4;
                mem_note(op[4], a, v, x.sel);
                hold = op[4] ? 1 : 6;
                if (!op[4]) v = m[a];
            end
            x.need[x.sel] = 1'b1;
            x.t[x.sel] = hold;
            if (x.sel) eb = v;
            else ea = v;
        end
        iss_q.push_back(x);
        send(op);
        if (x.two) send(b2);
    endtask

    // quiet spell with a stray read strobe that must be ignored
    task automatic idle();
        instr_valid_i <= 1'b0;
        repeat (16) @(posedge core_clk_i);
        mem_rvalid_i <= 1'b1;
        mem_rdata_i  <= $urandom;
        @(posedge core_clk_i);
        mem_rvalid_i <= 1'b0;
        @(negedge core_clk_i);
        chk(acc_first_o === ea, acc_first_o, ea);
        chk(acc_second_o === eb, acc_second_o, eb);
        @(posedge core_clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        ea = 32'h0;
        eb = 32'h0;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk(acc_first_o === 32'h0 && acc_second_o === 32'h0, acc_first_o, 32'h0);
        @(posedge core_clk_i);
    endtask

    // ------------------------------------------------------------------
    // memory side: answers reads with the modelled word
    // ------------------------------------------------------------------
    initial begin
        forever begin
            @(negedge core_clk_i);
            if (mem_req_o === 1'b1 && mem_we_o === 1'b0 && rd_q.size() > 0) begin
                lat = $urandom_range(3, 1);
                repeat (lat) @(posedge core_clk_i);
                mem_rvalid_i <= 1'b1;
                mem_rdata_i  <= rd_q.pop_front();
                @(posedge core_clk_i);
                mem_rvalid_i <= 1'b0;
                mem_rdata_i  <= ~mem_rdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // monitor: takes the oldest note whenever a result shows
    // ------------------------------------------------------------------
    always @(negedge core_clk_i) begin
        if (rst_i) begin
            lastt = -10;
            lastgap = 1;
            pst = 1'b0;
            ld_pend = 1'b0;
            free_at = '{0, 0, 0};
        end else begin
            if (ld_pend) begin
                got = ld_e[32] ? acc_second_o : acc_first_o;
                chk(got === ld_e[31:0], got, ld_e[31:0]);
                ld_pend = 1'b0;
            end
            if (mem_rvalid_i === 1'b1 && ld_q.size() > 0) begin
                ld_e = ld_q.pop_front();
                ld_pend = 1'b1;
            end
            if (mem_req_o === 1'b1) begin
                mr = (mem_q.size() > 0) ? mem_q.pop_front() : fgls_mreq_s'{1'b1, 12'hFFF, 32'h0};
                chk(mem_we_o === mr.we && mem_addr_o === mr.addr, {20'h0, mem_addr_o},
                    {20'h0, mr.addr});
                if (mr.we) chk(mem_wdata_o === mr.data, mem_wdata_o, mr.data);
            end
            if (issue_o === 1'b1) begin
                e = (iss_q.size() > 0) ? iss_q.pop_front() : fgls_ent_s'{default: 0};
                chk(e.need !== 3'b000 || e.two || e.chk, 32'h0, 32'h1);
                if (e.chk) begin
                    got = e.sel ? acc_second_o : acc_first_o;
                    chk(got === e.val, got, e.val);
                end
                sp = lastt + lastgap;
                rb = 0;
                for (int r = 0; r < 3; r++)
                    if (e.need[r] && free_at[r] > rb) rb = free_at[r];
                if (!e.fresh) begin
                    lo = (rb > sp) ? rb : sp;
                    tol = (rb > sp || pst) ? 1 : 0;
                    chk(cyc >= lo && cyc <= lo + tol, 32'(cyc), 32'(lo));
                    pst = (rb > sp);
                end else begin
                    pst = 1'b0;
                end
                for (int r = 0; r < 3; r++) if (e.need[r]) free_at[r] = cyc + e.t[r];
                lastt = cyc;
                lastgap = e.two ? 2 : 1;
            end
        end
    end

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        #2000000;
        err_count++;
        close_out();
    end

    initial begin
        logic [7:0] dir [18];
        int         n;
        rst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_byte_i = 8'h00;
        mem_rvalid_i = 1'b0;
        mem_rdata_i = 32'h0;
        dir = '{8'hDF, 8'h60, 8'hDA, 8'h5F, 8'hC7, 8'h7F, 8'hD5, 8'h40, 8'h9F,
                8'h3D, 8'h3F, 8'h3C, 8'h3E, 8'hF1, 8'hA1, 8'hB2, 8'hE2, 8'h8F};
        void'($urandom(62));
        for (int i = 0; i < 4096; i++) m[i] = $urandom;
        do_reset();
        for (int i = 0; i < 18; i++) exec(dir[i], 8'h34, i == 0);
        idle();
        for (int k = 0; k < 60; k++) begin
            if (k == 30) do_reset();
            n = $urandom_range(8, 1);
            for (int i = 0; i < n; i++)
                exec(8'($urandom_range(255, 60)), 8'($urandom), i == 0);
            idle();
        end
        chk(iss_q.size() == 0 && mem_q.size() == 0 && ld_q.size() == 0,
            32'(iss_q.size()), 32'h0);
        close_out();
    end

endmodule
